//--- verilog/rio_defs.svh
// Constants of the remote I/O master status and configuration block.
// Assumes a 40 MHz system clock and word-aligned Avalon-MM byte addresses.
//
// Behaviour
// - Unit-ready lamp on only while powered and the host has recognised the unit.
// - Input-single-word lamp on for one input word, off for two words.
// - Output-single-word lamp on for one output word, off for two words.
// - Link-ready lamp on in normal transmission, off on any transmission error.
// - Keep-on-error lamp lit whenever input retention on error is selected.
// - Transmit lamp flashes when active, steady on error, off on master fault.
// - Terminator lamp on at power-up, off when found, flashes if several.
// - Address-error lamp steady for slave addresses 28 to 30, flashes otherwise.
// - Slave alarm lamp latches on an output fault, without recording the slave.
// - Expansion transmit lamp flashes, steady on error, off on own fault.
// - Keep switch on freezes inputs on error; off clears every input bit.
// - Master output width one word when switch 2 on, two words when off.
// - Master input width one word when switch 1 on, two words when off.
// - A master fault disables retention at master and all expansion masters; the code retains inputs of expansion master 0 only.
// - An expansion fault disables retention there but keeps it at the master.
// - On a line break, words still received keep updating and retaining.
// - Expansion master is unit 2 when its switch 2 is on, else unit 1.
// - Expansion width one word when its switch 1 is on, two when off.
// - Switches are sampled once after reset; later changes need a new reset.
// - Link-ready relay closes exactly while the link-ready lamp is lit.
`ifndef RIO_DEFS_SVH
`define RIO_DEFS_SVH

`define RIO_OFS_CONFIG    5'h00
`define RIO_OFS_CONTROL   5'h04
`define RIO_OFS_STATUS    5'h08
`define RIO_OFS_MIN_LO    5'h0C
`define RIO_OFS_MIN_HI    5'h10
`define RIO_OFS_EIN_LO    5'h14
`define RIO_OFS_EIN_HI    5'h18

`define RIO_SW_IN_SINGLE  0
`define RIO_SW_OUT_SINGLE 1
`define RIO_SW_KEEP       2
`define RIO_SW_UNIT2      1

`define RIO_CTL_HOST_OK   0
`define RIO_CTL_ALM_CLR   1

`define RIO_ADDR_ERR_LO   5'h1C
`define RIO_ADDR_ERR_HI   5'h1E

`define RIO_CLK_HZ        40000000
`define RIO_FLASH_HALF_MS 250
`define RIO_FLASH_HALF_CYC ((`RIO_CLK_HZ / 1000) * `RIO_FLASH_HALF_MS)

`endif

//--- verilog/rio_pkg.sv
// Types and helper functions of the remote I/O master status block.
// Assumes nothing of its surroundings.
`default_nettype none
package rio_pkg;

    typedef enum logic [1:0]
    {
        RIO_LAMP_OFF   = 2'b00,
        RIO_LAMP_ON    = 2'b01,
        RIO_LAMP_FLASH = 2'b10
    } rio_lamp_t;

    // Drives a lamp from its display mode and the shared flash phase.
    function automatic logic rio_lamp(input rio_lamp_t mode, input logic phase);
        rio_lamp = (mode == RIO_LAMP_ON) || ((mode == RIO_LAMP_FLASH) && phase);
    endfunction

    // Next value of one delivered input word: fresh data, retained, or cleared.
    function automatic logic [15:0] rio_word_nxt(input logic [15:0] cur,
                                                 input logic [15:0] fresh,
                                                 input logic        ok,
                                                 input logic        err,
                                                 input logic        keep,
                                                 input logic        used);
        if (!used)
            rio_word_nxt = 16'h0000;
        else if (ok)
            rio_word_nxt = fresh;
        else if (err && !keep)
            rio_word_nxt = 16'h0000;
        else
            rio_word_nxt = cur;
    endfunction

endpackage
`default_nettype wire

//--- verilog/rio_blink.sv
// Free-running flash phase generator shared by all flashing lamps.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module rio_blink
#(
    parameter int HALF_CYC = 10000000
)
(
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    output logic      phase
);
    logic [23:0] cnt_r;
    logic        phase_r;
    wire         wrap = (cnt_r == 24'(HALF_CYC - 1));

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt_r   <= 24'h000000;
            phase_r <= 1'b0;
        end
        else
        begin
            cnt_r   <= wrap ? 24'h000000 : cnt_r + 24'h000001;
            phase_r <= wrap ? ~phase_r : phase_r;
        end
    end

    assign phase = phase_r;
endmodule
`default_nettype wire

//--- verilog/rio_master.sv
// Configuration, input retention and indicator logic of a remote I/O master
// with two expansion masters. Link events arrive as synchronous levels from
// the line engine; the host reaches the registers over Avalon-MM.
//
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "rio_defs.svh"
module rio_master
    import rio_pkg::*;
#(
    parameter int FLASH_HALF_CYC = `RIO_FLASH_HALF_CYC
)
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [3:0]  sw_master,
    input  wire logic [1:0]  sw_exp0,
    input  wire logic [1:0]  sw_exp1,
    input  wire logic        trans_err,
    input  wire logic        master_fault,
    input  wire logic [1:0]  exp_fault,
    input  wire logic        term_search,
    input  wire logic        transmitting,
    input  wire logic [1:0]  term_count,
    input  wire logic        addr_err,
    input  wire logic [4:0]  addr_err_slave,
    input  wire logic        out_fault_evt,
    input  wire logic [31:0] min_data,
    input  wire logic [1:0]  min_word_ok,
    input  wire logic [31:0] ein_data,
    input  wire logic [1:0]  ein_word_ok,
    output logic             unit_ready_lamp,
    output logic             input_single_word_lamp,
    output logic             output_single_word_lamp,
    output logic             link_ready_lamp,
    output logic             link_ready_relay,
    output logic             keep_lamp,
    output logic             tr_lamp,
    output logic             term_lamp,
    output logic             slave_address_error_lamp,
    output logic             slave_alarm_lamp,
    output logic             slave_alarm_relay,
    output logic [1:0]       exp_unit2_lamp,
    output logic [1:0]       exp_single_word_lamp,
    output logic [1:0]       exp_tr_lamp
);
    logic        sampled_r;
    logic [3:0]  cfg_m_r;
    logic [1:0]  cfg_e0_r;
    logic [1:0]  cfg_e1_r;
    logic        host_ok_r;
    logic        alarm_r;
    logic [31:0] min_r;
    logic [31:0] ein_r;
    logic        wait_r;
    logic [31:0] rdata_r;
    logic        ready_l_r;
    logic        in1_l_r;
    logic        out1_l_r;
    logic        link_l_r;
    logic        relay_r;
    logic        keep_l_r;
    logic        tr_l_r;
    logic        term_l_r;
    logic        adr_l_r;
    logic [1:0]  unit2_l_r;
    logic [1:0]  e1w_l_r;
    logic [1:0]  etr_l_r;
    logic        phase;

    rio_blink #(.HALF_CYC(FLASH_HALF_CYC)) u_blink
    (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .phase   (phase)
    );

    // Bus decode; one wait cycle, then the answer edge.
    wire        req       = avs_read || avs_write;
    wire        take      = req && !wait_r;
    wire        wr_ctl    = take && avs_write && (avs_address == `RIO_OFS_CONTROL)
                            && avs_byteenable[0];
    wire        alm_clr   = wr_ctl && avs_writedata[`RIO_CTL_ALM_CLR];

    // Configuration as latched after reset.
    wire        in_single  = cfg_m_r[`RIO_SW_IN_SINGLE];
    wire        out_single = cfg_m_r[`RIO_SW_OUT_SINGLE];
    wire        keep_sel   = cfg_m_r[`RIO_SW_KEEP];

    // Retention qualifiers per unit.
    wire        m_err  = trans_err || master_fault;
    wire        m_keep = keep_sel && !master_fault;
    wire        e_err  = m_err || exp_fault[0];
    wire        e_keep = keep_sel && !master_fault && !exp_fault[0];

    wire [31:0] min_nxt;
    wire [31:0] ein_nxt;
    assign min_nxt[15:0]  = rio_word_nxt(min_r[15:0], min_data[15:0], min_word_ok[0],
                                         m_err, m_keep, 1'b1);
    assign min_nxt[31:16] = rio_word_nxt(min_r[31:16], min_data[31:16], min_word_ok[1],
                                         m_err, m_keep, !in_single);
    assign ein_nxt[15:0]  = rio_word_nxt(ein_r[15:0], ein_data[15:0], ein_word_ok[0],
                                         e_err, e_keep, 1'b1);
    assign ein_nxt[31:16] = rio_word_nxt(ein_r[31:16], ein_data[31:16], ein_word_ok[1],
                                         e_err, e_keep, !cfg_e0_r[0]);

    // Lamp modes.
    wire        link_ok   = !trans_err && !master_fault;
    rio_lamp_t  tr_mode;
    rio_lamp_t  term_mode;
    rio_lamp_t  adr_mode;
    rio_lamp_t  etr_mode0;
    rio_lamp_t  etr_mode1;
    wire        adr_range = (addr_err_slave >= `RIO_ADDR_ERR_LO)
                            && (addr_err_slave <= `RIO_ADDR_ERR_HI);

    assign tr_mode   = master_fault ? RIO_LAMP_OFF :
                       trans_err ? RIO_LAMP_ON :
                       (term_search || transmitting) ? RIO_LAMP_FLASH : RIO_LAMP_OFF;
    assign term_mode = (term_count == 2'b00) ? RIO_LAMP_ON :
                       (term_count == 2'b01) ? RIO_LAMP_OFF : RIO_LAMP_FLASH;
    assign adr_mode  = !addr_err ? RIO_LAMP_OFF :
                       adr_range ? RIO_LAMP_ON : RIO_LAMP_FLASH;
    assign etr_mode0 = exp_fault[0] ? RIO_LAMP_OFF :
                       trans_err ? RIO_LAMP_ON :
                       transmitting ? RIO_LAMP_FLASH : RIO_LAMP_OFF;
    assign etr_mode1 = exp_fault[1] ? RIO_LAMP_OFF :
                       trans_err ? RIO_LAMP_ON :
                       transmitting ? RIO_LAMP_FLASH : RIO_LAMP_OFF;

    wire [31:0] status_w = {20'h00000, alarm_r, adr_l_r, term_l_r, tr_l_r, etr_l_r,
                            keep_l_r, link_l_r, out1_l_r, in1_l_r, ready_l_r, sampled_r};
    wire [31:0] config_w = {24'h000000, cfg_e1_r, cfg_e0_r, cfg_m_r};
    wire [31:0] rdata_nxt =
        (avs_address == `RIO_OFS_CONFIG)  ? config_w :
        (avs_address == `RIO_OFS_CONTROL) ? {31'h00000000, host_ok_r} :
        (avs_address == `RIO_OFS_STATUS)  ? status_w :
        (avs_address == `RIO_OFS_MIN_LO)  ? {16'h0000, min_r[15:0]} :
        (avs_address == `RIO_OFS_MIN_HI)  ? {16'h0000, min_r[31:16]} :
        (avs_address == `RIO_OFS_EIN_LO)  ? {16'h0000, ein_r[15:0]} :
        (avs_address == `RIO_OFS_EIN_HI)  ? {16'h0000, ein_r[31:16]} : 32'h00000000;

    // Bus slave: waitrequest drops for one cycle per request.
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wait_r  <= 1'b1;
            rdata_r <= 32'h00000000;
        end
        else
        begin
            wait_r  <= !(req && wait_r);
            rdata_r <= (req && wait_r) ? rdata_nxt : rdata_r;
        end
    end

    // Switches are caught at the first edge after reset release and then frozen.
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sampled_r <= 1'b0;
            cfg_m_r   <= 4'h0;
            cfg_e0_r  <= 2'h0;
            cfg_e1_r  <= 2'h0;
        end
        else if (!sampled_r)
        begin
            sampled_r <= 1'b1;
            cfg_m_r   <= sw_master;
            cfg_e0_r  <= sw_exp0;
            cfg_e1_r  <= sw_exp1;
        end
    end

    // Host control, alarm latch and delivered input words.
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            host_ok_r <= 1'b0;
            alarm_r   <= 1'b0;
            min_r     <= 32'h00000000;
            ein_r     <= 32'h00000000;
        end
        else
        begin
            host_ok_r <= wr_ctl ? avs_writedata[`RIO_CTL_HOST_OK] : host_ok_r;
            alarm_r   <= out_fault_evt || (alarm_r && !alm_clr);
            min_r     <= min_nxt;
            ein_r     <= ein_nxt;
        end
    end

    // Indicator registers.
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ready_l_r <= 1'b0;
            in1_l_r   <= 1'b0;
            out1_l_r  <= 1'b0;
            link_l_r  <= 1'b0;
            relay_r   <= 1'b0;
            keep_l_r  <= 1'b0;
            tr_l_r    <= 1'b0;
            term_l_r  <= 1'b1;
            adr_l_r   <= 1'b0;
            unit2_l_r <= 2'h0;
            e1w_l_r   <= 2'h0;
            etr_l_r   <= 2'h0;
        end
        else
        begin
            ready_l_r <= host_ok_r;
            in1_l_r   <= in_single;
            out1_l_r  <= out_single;
            link_l_r  <= link_ok;
            relay_r   <= link_ok;
            keep_l_r  <= keep_sel;
            tr_l_r    <= rio_lamp(tr_mode, phase);
            term_l_r  <= rio_lamp(term_mode, phase);
            adr_l_r   <= rio_lamp(adr_mode, phase);
            unit2_l_r <= {cfg_e1_r[`RIO_SW_UNIT2], cfg_e0_r[`RIO_SW_UNIT2]};
            e1w_l_r   <= {cfg_e1_r[0], cfg_e0_r[0]};
            etr_l_r   <= {rio_lamp(etr_mode1, phase), rio_lamp(etr_mode0, phase)};
        end
    end

    assign avs_readdata             = rdata_r;
    assign avs_waitrequest          = wait_r;
    assign unit_ready_lamp          = ready_l_r;
    assign input_single_word_lamp   = in1_l_r;
    assign output_single_word_lamp  = out1_l_r;
    assign link_ready_lamp          = link_l_r;
    assign link_ready_relay         = relay_r;
    assign keep_lamp                = keep_l_r;
    assign tr_lamp                  = tr_l_r;
    assign term_lamp                = term_l_r;
    assign slave_address_error_lamp = adr_l_r;
    assign slave_alarm_lamp         = alarm_r;
    assign slave_alarm_relay        = alarm_r;
    assign exp_unit2_lamp           = unit2_l_r;
    assign exp_single_word_lamp     = e1w_l_r;
    assign exp_tr_lamp              = etr_l_r;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_host_set;
        wr_ctl && avs_writedata[`RIO_CTL_HOST_OK];
    endsequence

    sequence s_err_kept;
        trans_err && keep_sel && !master_fault && !min_word_ok[0] && sampled_r;
    endsequence

    a_ready_after_host: assert property (s_host_set |=> ##1 unit_ready_lamp)
        else $error("unit ready lamp not lit after host recognition");
    a_width_lamps: assert property (sampled_r
        |=> (input_single_word_lamp == in_single)
        && (output_single_word_lamp == out_single))
        else $error("word width lamps disagree with latched switches");
    a_link_err_off: assert property (trans_err |=> !link_ready_lamp)
        else $error("link ready lamp lit during transmission error");
    a_relay_mirror: assert property (link_ready_relay == link_ready_lamp)
        else $error("link ready relay differs from lamp");
    a_tr_fault_off: assert property (master_fault |=> !tr_lamp)
        else $error("transmit lamp lit on master fault");
    a_tr_error_on: assert property (trans_err && !master_fault |=> tr_lamp)
        else $error("transmit lamp not steady on error");
    a_term_single: assert property (term_count == 2'b01 |=> !term_lamp)
        else $error("terminator lamp lit with one terminator");
    a_addr_steady: assert property (addr_err && adr_range |=> slave_address_error_lamp)
        else $error("address error lamp not steady for high addresses");
    // The set beats a clear in the same cycle; only a later clear drops the alarm.
    a_alarm_set_wins: assert property (out_fault_evt
        |=> slave_alarm_lamp ##1 (slave_alarm_lamp || $past(alm_clr)))
        else $error("slave alarm lost after fault event");
    a_keep_freeze: assert property (s_err_kept |=> $stable(min_r[15:0]))
        else $error("kept input word changed during error");
    a_clear_input: assert property (
        trans_err && !keep_sel && !min_word_ok[0] && sampled_r
        |=> min_r[15:0] == 16'h0000)
        else $error("input word not cleared on error without keep");
    a_fault_no_keep: assert property (master_fault && !ein_word_ok[0]
        |=> ein_r[15:0] == 16'h0000)
        else $error("expansion input retained on master fault");
    a_cfg_frozen: assert property (sampled_r && $past(sampled_r) |-> $stable(cfg_m_r))
        else $error("configuration changed after sampling");
    a_bus_answer: assert property (req && wait_r |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle long");

    // Indicator levels follow their causes one edge later.
    a_host_ready_off: assert property (!host_ok_r |=> !unit_ready_lamp)
        else $error("ready lamp lit unrecognised");

    a_link_ok_on: assert property (!trans_err && !master_fault |=> link_ready_lamp)
        else $error("link ready lamp dark");

    a_keep_lamp: assert property (sampled_r |=> keep_lamp == keep_sel)
        else $error("keep lamp wrong");

    a_term_none: assert property (term_count == 2'b00 |=> term_lamp)
        else $error("terminator lamp dark");

    a_addr_off: assert property (!addr_err |=> !slave_address_error_lamp)
        else $error("address lamp lit");

    a_alarm_hold: assert property (slave_alarm_lamp && !alm_clr |=> slave_alarm_lamp)
        else $error("alarm dropped");

    a_unit2_lamps: assert property (sampled_r
        |=> exp_unit2_lamp == {cfg_e1_r[`RIO_SW_UNIT2], cfg_e0_r[`RIO_SW_UNIT2]})
        else $error("unit two lamps wrong");

    a_etr_fault_off: assert property (exp_fault[0] |=> !exp_tr_lamp[0])
        else $error("expansion lamp lit on fault");

    a_etr_error_on: assert property (trans_err && !exp_fault[0] |=> exp_tr_lamp[0])
        else $error("expansion lamp not steady");

    // Delivered input words.
    a_fresh_word: assert property (min_word_ok[0]
        |=> min_r[15:0] == $past(min_data[15:0]))
        else $error("fresh word not delivered");

    a_high_word_off: assert property (sampled_r && in_single
        |=> min_r[31:16] == 16'h0000)
        else $error("unused word not zero");

    a_exp_no_keep: assert property (exp_fault[0] && !ein_word_ok[0]
        |=> ein_r[15:0] == 16'h0000)
        else $error("expansion word kept");
endmodule
`default_nettype wire

//--- sim/rio_slaves_model.sv
// Behavioural model of the remote terminal slaves on the two-wire line.
// Assumes the bench sets line health and reports; outputs move after sys_clk edges.
`timescale 1ns/100ps
`default_nettype none
module rio_slaves_model
(
    input  wire logic        sys_clk,
    input  wire logic        line_ok,
    input  wire logic [1:0]  term_n,
    input  wire logic [4:0]  bad_addr,
    input  wire logic        bad_en,
    input  wire logic        out_fault,
    input  wire logic [31:0] data,
    output logic             trans_err,
    output logic             term_search,
    output logic             transmitting,
    output logic [1:0]       term_count,
    output logic             addr_err,
    output logic [4:0]       addr_err_slave,
    output logic             out_fault_evt,
    output logic [31:0]      min_data,
    output logic [31:0]      ein_data,
    output logic [1:0]       word_ok
);
    // Input words not delivered fresh are scrambled so stale data cannot pass.
    always_ff @(posedge sys_clk)
    begin
        trans_err      <= !line_ok;
        transmitting   <= line_ok;
        term_search    <= 1'b0;
        term_count     <= term_n;
        addr_err       <= bad_en;
        addr_err_slave <= bad_addr;
        out_fault_evt  <= out_fault;
        word_ok        <= line_ok ? 2'h3 : 2'h0;
        min_data       <= line_ok ? data : ~min_data;
        ein_data       <= line_ok ? ~data : ~ein_data;
    end
endmodule
`default_nettype wire

//--- sim/rio_master_tb.sv
// Self-checking bench of the remote I/O master status block.
// Assumes the slave model on the line side and Avalon-MM tasks on the host side.
`timescale 1ns/100ps
`default_nettype none
module rio_master_tb;
    logic        sys_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
    logic [4:0]  avs_address, bad_addr, addr_err_slave;
    logic [31:0] avs_writedata, avs_readdata, data, min_data, ein_data;
    logic [3:0]  avs_byteenable, sw_master;
    logic [1:0]  sw_exp0, sw_exp1, exp_fault, term_n, term_count, word_ok;
    logic [1:0]  exp_unit2_lamp, exp_single_word_lamp, exp_tr_lamp;
    logic        master_fault, line_ok, bad_en, out_fault, trans_err, term_search;
    logic        transmitting, addr_err, out_fault_evt, unit_ready_lamp, keep_lamp;
    logic        input_single_word_lamp, output_single_word_lamp, link_ready_lamp;
    logic        link_ready_relay, tr_lamp, term_lamp, slave_address_error_lamp;
    logic        slave_alarm_lamp, slave_alarm_relay;
    int          err_count, comparisons;

    rio_master #(.FLASH_HALF_CYC(4)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .sw_master(sw_master), .sw_exp0(sw_exp0), .sw_exp1(sw_exp1),
        .trans_err(trans_err), .master_fault(master_fault), .exp_fault(exp_fault),
        .term_search(term_search), .transmitting(transmitting), .term_count(term_count),
        .addr_err(addr_err), .addr_err_slave(addr_err_slave),
        .out_fault_evt(out_fault_evt), .min_data(min_data), .min_word_ok(word_ok),
        .ein_data(ein_data), .ein_word_ok(word_ok), .unit_ready_lamp(unit_ready_lamp),
        .input_single_word_lamp(input_single_word_lamp),
        .output_single_word_lamp(output_single_word_lamp),
        .link_ready_lamp(link_ready_lamp), .link_ready_relay(link_ready_relay),
        .keep_lamp(keep_lamp), .tr_lamp(tr_lamp), .term_lamp(term_lamp),
        .slave_address_error_lamp(slave_address_error_lamp),
        .slave_alarm_lamp(slave_alarm_lamp), .slave_alarm_relay(slave_alarm_relay),
        .exp_unit2_lamp(exp_unit2_lamp), .exp_single_word_lamp(exp_single_word_lamp),
        .exp_tr_lamp(exp_tr_lamp));

    rio_slaves_model partner (.sys_clk(sys_clk), .line_ok(line_ok), .term_n(term_n),
        .bad_addr(bad_addr), .bad_en(bad_en), .out_fault(out_fault), .data(data),
        .trans_err(trans_err), .term_search(term_search), .transmitting(transmitting),
        .term_count(term_count), .addr_err(addr_err), .addr_err_slave(addr_err_slave),
        .out_fault_evt(out_fault_evt), .min_data(min_data), .ein_data(ein_data),
        .word_ok(word_ok));

    always #12.5 sys_clk = ~sys_clk;

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Holds the request until waitrequest is sampled low, then releases it.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        @(posedge sys_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50)
        begin
            err_count++;
            conclude();
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask

    // Classifies a lamp over two flash periods: 0 off, 1 steady, 2 flashing, 3 unknown.
    task automatic lamp(input int sel, input logic [1:0] exp);
        int ones;
        logic v;
        ones = 0;
        repeat (16)
        begin
            @(posedge sys_clk);
            case (sel)
                0: v = tr_lamp;
                1: v = term_lamp;
                2: v = slave_address_error_lamp;
                3: v = exp_tr_lamp[0];
                default: v = exp_tr_lamp[1];
            endcase
            ones += (v === 1'b1) ? 1 : (v === 1'b0) ? 0 : 100;
        end
        chk({30'h0, ones > 16 ? 2'h3 : ones == 0 ? 2'h0 : ones == 16 ? 2'h1 : 2'h2}, {30'h0, exp});
    endtask

    task automatic run_cfg(input logic [3:0] sm, input logic [1:0] e0, input logic [1:0] e1);
        logic [31:0] q;
        logic [31:0] mk;
        logic [31:0] ek;
        mk = sm[2] ? 32'h3C3C : 32'h0;
        ek = sm[2] ? 32'hC3C3 : 32'h0;
        sys_rst      <= 1'b1;
        line_ok      <= 1'b1;
        master_fault <= 1'b0;
        exp_fault    <= 2'h0;
        term_n       <= 2'h0;
        bad_en       <= 1'b0;
        out_fault    <= 1'b0;
        sw_master    <= sm;
        sw_exp0      <= e0;
        sw_exp1      <= e1;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        sw_master <= ~sm;
        sw_exp0   <= ~e0;
        sw_exp1   <= ~e1;
        bus(1'b1, 5'h00, 32'hFFFFFFFF, q);
        rd(5'h00, {24'h0, e1, e0, sm});
        chk(input_single_word_lamp, sm[0]);
        chk(output_single_word_lamp, sm[1]);
        chk(keep_lamp, sm[2]);
        chk(exp_unit2_lamp, {e1[1], e0[1]});
        chk(exp_single_word_lamp, {e1[0], e0[0]});
        lamp(1, 2'h1);
        chk(unit_ready_lamp, 1'b0);
        bus(1'b1, 5'h04, 32'h1, q);
        repeat (2) @(posedge sys_clk);
        chk(unit_ready_lamp, 1'b1);
        chk({link_ready_lamp, link_ready_relay}, 2'h3);
        lamp(0, 2'h2);
        lamp(3, 2'h2);
        lamp(4, 2'h2);
        rd(5'h0C, 32'h3C3C);
        rd(5'h10, sm[0] ? 32'h0 : 32'hA5A5);
        rd(5'h14, 32'hC3C3);
        rd(5'h18, e0[0] ? 32'h0 : 32'h5A5A);
        line_ok <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk({link_ready_lamp, link_ready_relay}, 2'h0);
        lamp(0, 2'h1);
        lamp(3, 2'h1);
        rd(5'h0C, mk);
        rd(5'h14, ek);
        exp_fault <= 2'h1;
        repeat (3) @(posedge sys_clk);
        lamp(3, 2'h0);
        lamp(4, 2'h1);
        rd(5'h0C, mk);
        rd(5'h14, 32'h0);
        master_fault <= 1'b1;
        repeat (3) @(posedge sys_clk);
        lamp(0, 2'h0);
        rd(5'h0C, 32'h0);
        master_fault <= 1'b0;
        exp_fault    <= 2'h0;
        line_ok      <= 1'b1;
        for (int n = 1; n < 4; n++)
        begin
            term_n <= n[1:0];
            repeat (3) @(posedge sys_clk);
            lamp(1, n == 1 ? 2'h0 : 2'h2);
        end
        for (int a = 26; a < 32; a++)
        begin
            bad_addr <= a[4:0];
            bad_en   <= 1'b1;
            repeat (3) @(posedge sys_clk);
            lamp(2, (a >= 28 && a <= 30) ? 2'h1 : 2'h2);
        end
        out_fault <= 1'b1;
        @(posedge sys_clk);
        out_fault <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk({slave_alarm_lamp, slave_alarm_relay}, 2'h3);
        bus(1'b1, 5'h04, 32'h3, q);
        repeat (2) @(posedge sys_clk);
        chk({slave_alarm_lamp, slave_alarm_relay, unit_ready_lamp}, 3'h1);
        rd(5'h1C, 32'h0);
    endtask

    initial
    begin
        sys_clk        = 1'b0;
        sys_rst        = 1'b1;
        avs_address    = 5'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'hF;
        data           = 32'hA5A53C3C;
        bad_addr       = 5'h00;
        err_count      = 0;
        comparisons    = 0;
        run_cfg(4'h4, 2'h2, 2'h1);
        run_cfg(4'h3, 2'h1, 2'h2);
        conclude();
    end
endmodule
`default_nettype wire
